// >>> fdpm_pkg.sv
// Constants and types for the fast threshold detector and peak monitor.
// Assumes one sample clock; samples arrive as 14-bit two's complement words.
package fdpm_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CH   = 4;
    localparam int SAMPLE_W = 14;
    localparam int WORD_W   = 16;
    localparam int MAG_W    = 13;
    localparam int DWELL_W  = 16;
    localparam int PERIOD_W = 24;
    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [MAG_W-1:0] MAG_FULL = 13'h1fff;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_UPPER_LO = 10'h247;
    localparam logic [ADDR_W-1:0] OFS_UPPER_HI = 10'h248;
    localparam logic [ADDR_W-1:0] OFS_LOWER_LO = 10'h249;
    localparam logic [ADDR_W-1:0] OFS_LOWER_HI = 10'h24a;
    localparam logic [ADDR_W-1:0] OFS_DWELL_LO = 10'h24b;
    localparam logic [ADDR_W-1:0] OFS_DWELL_HI = 10'h24c;
    localparam logic [ADDR_W-1:0] OFS_MON_CTRL = 10'h270;
    localparam logic [ADDR_W-1:0] OFS_LINK_A   = 10'h279;
    localparam logic [ADDR_W-1:0] OFS_LINK_B   = 10'h27a;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int MON_EN_BIT   = 1;
    localparam int FLAG_RD_LSB  = 4;
    localparam int LINK_B_BIT   = 1;
    localparam logic [1:0] LINK_A_ON = 2'h3;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    // ------------------------------------------------------------
    // Serial monitor frame
    // ------------------------------------------------------------
    localparam int FRAME_LEN = 25;
    localparam int SUB_LEN   = 5;
    localparam int SUB_CNT   = 5;
    localparam int SUB_DATA  = 4;
    localparam int CNT_W     = 5;
    localparam logic START_BIT = 1'b0;
    localparam logic IDLE_BIT  = 1'b1;
    localparam logic [CNT_W-1:0] FRAME_CNT = 5'h19;

    typedef struct packed {
        logic [MAG_W-1:0]   upper;
        logic [MAG_W-1:0]   lower;
        logic [DWELL_W-1:0] dwell;
    } fdpm_cfg_type;
endpackage : fdpm_pkg

// >>> fdpm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on sys_clk.
`timescale 1ns/1ns
module fdpm_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : PW'(wr_q + 1'b1);
            if (pop)
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : PW'(rd_q + 1'b1);
            cnt_q <= (PW+1)'(cnt_q + push - pop);
        end
    end
endmodule : fdpm_fifo

// >>> fdpm_channel.sv
// One channel: magnitude, hysteresis flag and peak storage/holding.
// Assumes monitor strobes are aligned with the registered magnitude.
`timescale 1ns/1ns
module fdpm_channel
    import fdpm_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire fdpm_cfg_type        cfg,
    input  wire logic                mon_strobe,
    input  wire logic                mon_seed,
    input  wire logic                mon_capture,
    output logic                     threshold_flag,
    output logic [MAG_W-1:0]         peak_hold
);
    logic [SAMPLE_W-1:0] abs_s;
    logic [MAG_W-1:0]    mag_q;
    logic [DWELL_W-1:0]  low_cnt_q;
    logic                flag_q;
    logic [MAG_W-1:0]    store_q;
    logic                seed_pend_q;
    logic [MAG_W-1:0]    best;

    // ------------------------------------------------------------
    // Magnitude at converter resolution
    // ------------------------------------------------------------
    assign abs_s = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            mag_q <= '0;
        else
            mag_q <= (abs_s > SAMPLE_W'(MAG_FULL)) ? MAG_FULL : abs_s[MAG_W-1:0];
    end

    // ------------------------------------------------------------
    // Hysteresis flag
    // ------------------------------------------------------------
    // restart on high sample
    always_ff @(posedge sys_clk)
    begin
        if (reset || mag_q >= cfg.lower)
            low_cnt_q <= '0;
        else if (low_cnt_q != '1)
            low_cnt_q <= low_cnt_q + 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (mag_q > cfg.upper)
            flag_q <= 1'b1;
        else if (mag_q < cfg.lower && low_cnt_q >= cfg.dwell)
            flag_q <= 1'b0;
    end
    assign threshold_flag = flag_q;

    // ------------------------------------------------------------
    // Peak storage and holding
    // ------------------------------------------------------------
    assign best = seed_pend_q ? mag_q : ((mag_q > store_q) ? mag_q : store_q);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            store_q     <= '0;
            seed_pend_q <= 1'b1;
        end
        else if (mon_seed || (mon_strobe && mon_capture))
            seed_pend_q <= 1'b1;
        else if (mon_strobe)
        begin
            store_q     <= best;
            seed_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            peak_hold <= '0;
        else if (mon_strobe && mon_capture)
            peak_hold <= best;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_flag_set;
        @(posedge sys_clk) disable iff (reset)
        (mag_q > cfg.upper) |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set above upper");

    property p_flag_hold;
        @(posedge sys_clk) disable iff (reset)
        (flag_q && mag_q >= cfg.lower) |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared on high sample");

    property p_flag_clear;
        @(posedge sys_clk) disable iff (reset)
        $fell(flag_q) |-> ($past(low_cnt_q) >= $past(cfg.dwell)) && ($past(mag_q) < $past(cfg.lower));
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag cleared before dwell");

    property p_peak_keep;
        @(posedge sys_clk) disable iff (reset)
        (mon_strobe && !mon_capture && !mon_seed && !seed_pend_q && mag_q > store_q)
            |=> store_q == $past(mag_q);
    endproperty
    a_peak_keep: assert property (p_peak_keep) else $error("larger magnitude not kept");

    property p_hold_copy;
        @(posedge sys_clk) disable iff (reset)
        (mon_strobe && mon_capture && !seed_pend_q && store_q >= mag_q) |=> peak_hold == $past(store_q);
    endproperty
    a_hold_copy: assert property (p_hold_copy) else $error("peak not copied to holding");
endmodule : fdpm_channel

// >>> fdpm_top.sv
// Fast threshold detection, peak signal monitor and embedded serial monitor.
// Assumes samples and the decimated strobe come from logic on sys_clk.
//
// Behaviour
// - Flag sets at once when magnitude rises above the upper threshold.
// - Flag clears only after magnitude stays below lower threshold past dwell.
// - Upper threshold flag asserts within 30 cycles of the triggering sample.
// - Upper compare uses converter magnitude, full scale two to the thirteenth.
// - Lower threshold is 13 bits, compared at full converter resolution.
// - Dwell time is 1 to 65535 cycles from two dwell registers.
// - Peak detector keeps the largest 13-bit magnitude within the period.
// - Observation period is one global 24-bit value in output samples.
// - Control bit 1 starts peak detection; period loaded by software first.
// - Enabling loads the period into a timer decremented per decimated clock.
// - Each magnitude compares with hidden storage, larger kept; seeded by input.
// - At count 1: copy peak to holding, reload timer, reseed storage.
// - Holding value is readable and also sent in the sample stream.
// - Link embedding needs bits 1:0 of one register and bit 1 of next.
// - Up to three control bits, MSB first; one bit uses the MSB only.
// - 25-bit frame, MSB first, five 5-bit subframes each with a start bit.
// - Each of four channels has its own detector and flag pin.
`timescale 1ns/1ns
module fdpm_top
    import fdpm_pkg::*;
#(
    parameter int CH    = NUM_CH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic [ADDR_W-1:0]            reg_addr,
    input  wire logic                         reg_wr_en,
    input  wire logic                         reg_rd_en,
    input  wire logic [DATA_W-1:0]            reg_wdata,
    output logic [DATA_W-1:0]                 reg_rdata,
    input  wire logic [CH-1:0][SAMPLE_W-1:0]  adc_sample,
    input  wire logic                         dec_strobe,
    output logic                              in_ready,
    input  wire logic [PERIOD_W-1:0]          monitor_period_value,
    input  wire logic [1:0]                   ctrl_bit_count,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [CH*WORD_W-1:0]              out_data,
    output logic [CH-1:0][MAG_W-1:0]          monitor_peak_hold,
    output logic                              embedded_monitor_serial,
    output logic                              threshold_flag_pin_a,
    output logic                              threshold_flag_pin_b,
    output logic                              threshold_flag_pin_c,
    output logic                              threshold_flag_pin_d
);
    fdpm_cfg_type            cfg_q;
    logic                    mon_en_q;
    logic [1:0]              link_a_q;
    logic                    link_b_q;
    logic [CH-1:0]           threshold_flag;
    logic                    strobe_q;
    logic                    run_q;
    logic [PERIOD_W-1:0]     timer_q;
    logic                    start;
    logic                    cap;
    logic                    emb_on;
    logic                    push;
    logic [CH-1:0][CNT_W-1:0]     left_q;
    logic [CH-1:0][FRAME_LEN-1:0] shift_q;
    logic [CH-1:0]           mon_bit;
    logic [CH*WORD_W-1:0]    word;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // 13-bit thresholds, 16-bit dwell
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cfg_q    <= '0;
            mon_en_q <= 1'b0;
            link_a_q <= '0;
            link_b_q <= 1'b0;
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                OFS_UPPER_LO: cfg_q.upper[7:0]          <= reg_wdata;
                OFS_UPPER_HI: cfg_q.upper[MAG_W-1:8]    <= reg_wdata[MAG_W-9:0];
                OFS_LOWER_LO: cfg_q.lower[7:0]          <= reg_wdata;
                OFS_LOWER_HI: cfg_q.lower[MAG_W-1:8]    <= reg_wdata[MAG_W-9:0];
                OFS_DWELL_LO: cfg_q.dwell[7:0]          <= reg_wdata;
                OFS_DWELL_HI: cfg_q.dwell[DWELL_W-1:8]  <= reg_wdata;
                OFS_MON_CTRL: mon_en_q <= reg_wdata[MON_EN_BIT];
                OFS_LINK_A:   link_a_q <= reg_wdata[1:0];
                OFS_LINK_B:   link_b_q <= reg_wdata[LINK_B_BIT];
                default:      mon_en_q <= mon_en_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reg_rdata <= REG_RST;
        else if (reg_rd_en)
        begin
            case (reg_addr)
                OFS_UPPER_LO: reg_rdata <= cfg_q.upper[7:0];
                OFS_UPPER_HI: reg_rdata <= DATA_W'(cfg_q.upper[MAG_W-1:8]);
                OFS_LOWER_LO: reg_rdata <= cfg_q.lower[7:0];
                OFS_LOWER_HI: reg_rdata <= DATA_W'(cfg_q.lower[MAG_W-1:8]);
                OFS_DWELL_LO: reg_rdata <= cfg_q.dwell[7:0];
                OFS_DWELL_HI: reg_rdata <= cfg_q.dwell[DWELL_W-1:8];
                OFS_MON_CTRL:
                begin
                    reg_rdata <= REG_RST;
                    reg_rdata[MON_EN_BIT] <= mon_en_q;
                    reg_rdata[FLAG_RD_LSB +: NUM_CH] <= threshold_flag[NUM_CH-1:0];
                end
                OFS_LINK_A:   reg_rdata <= DATA_W'(link_a_q);
                OFS_LINK_B:   reg_rdata <= DATA_W'(link_b_q) << LINK_B_BIT;
                default:      reg_rdata <= REG_RST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Monitor period timer
    // ------------------------------------------------------------
    assign start = mon_en_q && !run_q;
    assign cap   = run_q && strobe_q && (timer_q <= PERIOD_W'(1));

    // Aligns the decimated strobe with the registered magnitude
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            strobe_q <= 1'b0;
        else
            strobe_q <= dec_strobe;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            run_q   <= 1'b0;
            timer_q <= '0;
        end
        else if (!mon_en_q)
            run_q <= 1'b0;
        else if (start)
        begin
            run_q   <= 1'b1;
            timer_q <= monitor_period_value;
        end
        else if (cap)
            timer_q <= monitor_period_value;
        else if (strobe_q)
            timer_q <= timer_q - 1'b1;
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // one detector per channel
    generate
        for (genvar c = 0; c < CH; c++)
        begin : g_ch
            fdpm_channel u_ch (
                .sys_clk        (sys_clk),
                .reset          (reset),
                .sample         (adc_sample[c]),
                .cfg            (cfg_q),
                .mon_strobe     (strobe_q && run_q),
                .mon_seed       (start),
                .mon_capture    (cap),
                .threshold_flag (threshold_flag[c]),
                .peak_hold      (monitor_peak_hold[c])
            );
        end
    endgenerate

    assign threshold_flag_pin_a = threshold_flag[0];
    assign threshold_flag_pin_b = threshold_flag[1];
    assign threshold_flag_pin_c = threshold_flag[2];
    assign threshold_flag_pin_d = threshold_flag[3];

    // ------------------------------------------------------------
    // Serial monitor frame
    // ------------------------------------------------------------
    // start bit then four payload bits per subframe
    function automatic logic [FRAME_LEN-1:0] make_frame(input logic [MAG_W-1:0] peak);
        logic [SUB_CNT*SUB_DATA-1:0] pay;
        logic [FRAME_LEN-1:0]        f;
        pay = (SUB_CNT*SUB_DATA)'(peak);
        f   = '0;
        for (int k = 0; k < SUB_CNT; k++)
        begin
            f[FRAME_LEN-1-k*SUB_LEN] = START_BIT;
            f[FRAME_LEN-2-k*SUB_LEN -: SUB_DATA] = pay[SUB_CNT*SUB_DATA-1-k*SUB_DATA -: SUB_DATA];
        end
        return f;
    endfunction : make_frame

    assign emb_on = (link_a_q == LINK_A_ON) && link_b_q && (ctrl_bit_count != 2'h0);
    assign push   = dec_strobe && in_ready;

    generate
        for (genvar c = 0; c < CH; c++)
        begin : g_ser
            logic [WORD_W-1:0] w;
            logic              cap_seen_q;

            // Frame loads one cycle after capture, when holding is updated
            always_ff @(posedge sys_clk)
            begin
                if (reset)
                    cap_seen_q <= 1'b0;
                else
                    cap_seen_q <= cap;
            end

            always_ff @(posedge sys_clk)
            begin
                if (reset)
                begin
                    left_q[c]  <= '0;
                    shift_q[c] <= '0;
                end
                else if (cap_seen_q)
                begin
                    left_q[c]  <= FRAME_CNT;
                    shift_q[c] <= make_frame(monitor_peak_hold[c]);
                end
                else if (push && left_q[c] != '0)
                begin
                    left_q[c]  <= left_q[c] - 1'b1;
                    shift_q[c] <= shift_q[c] << 1;
                end
            end

            assign mon_bit[c] = (left_q[c] != '0) ? shift_q[c][FRAME_LEN-1] : IDLE_BIT;

            // control bits fill from the MSB down
            always_comb
            begin
                w = {adc_sample[c], 2'h0};
                if (emb_on)
                begin
                    case (ctrl_bit_count)
                        2'h1:    w[0]   = mon_bit[c];
                        2'h2:    w[1:0] = {mon_bit[c], 1'b0};
                        2'h3:    w[2:0] = {mon_bit[c], 2'h0};
                        default: w      = {adc_sample[c], 2'h0};
                    endcase
                end
            end
            assign word[c*WORD_W +: WORD_W] = w;
        end
    endgenerate

    assign embedded_monitor_serial = mon_bit[0];

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    fdpm_fifo #(
        .WIDTH (CH*WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (dec_strobe),
        .in_ready  (in_ready),
        .in_data   (word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ctrl_write;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr_en && reg_addr == OFS_MON_CTRL) |=> mon_en_q == $past(reg_wdata[MON_EN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("enable bit not written");

    property p_timer_load;
        @(posedge sys_clk) disable iff (reset)
        start |=> run_q && timer_q == $past(monitor_period_value);
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("period not loaded on enable");

    property p_timer_dec;
        @(posedge sys_clk) disable iff (reset)
        (mon_en_q && run_q && strobe_q && timer_q > PERIOD_W'(1)) |=> timer_q == $past(timer_q) - 1'b1;
    endproperty
    a_timer_dec: assert property (p_timer_dec) else $error("timer did not decrement");

    property p_timer_reload;
        @(posedge sys_clk) disable iff (reset)
        (cap && mon_en_q) |=> timer_q == $past(monitor_period_value);
    endproperty
    a_timer_reload: assert property (p_timer_reload) else $error("timer not reloaded");

    sequence s_capture;
        cap ##1 1'b1;
    endsequence

    sequence s_frame_loaded;
        left_q[0] == FRAME_CNT && shift_q[0] == make_frame(monitor_peak_hold[0]);
    endsequence

    property p_frame_load;
        @(posedge sys_clk) disable iff (reset)
        s_capture |=> s_frame_loaded;
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("frame not loaded after capture");

    property p_one_ctrl_bit;
        @(posedge sys_clk) disable iff (reset)
        (emb_on && ctrl_bit_count == 2'h1) |-> word[0] == mon_bit[0] && word[WORD_W-1:2] == adc_sample[0];
    endproperty
    a_one_ctrl_bit: assert property (p_one_ctrl_bit) else $error("control bit misplaced");

    property p_advance;
        @(posedge sys_clk) disable iff (reset)
        (push && !cap_any() && left_q[0] != '0) |=> left_q[0] == $past(left_q[0]) - 1'b1;
    endproperty
    a_advance: assert property (p_advance) else $error("frame did not advance");

    function automatic logic cap_any();
        return g_ser[0].cap_seen_q;
    endfunction : cap_any
endmodule : fdpm_top

// >>> fdpm_sink.sv
// Stream receiver model: accepts words and rebuilds monitor frames.
// Assumes one control bit, carried in bit 0 of channel 0.
`timescale 1ns/1ns
module fdpm_sink
    import fdpm_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 stall,
    input  wire logic                 listen,
    input  wire logic                 out_valid,
    input  wire logic [63:0]          out_data,
    output logic                      out_ready,
    output logic [FRAME_LEN-1:0]      frame_q,
    output int                        frames_q
);
    int                   n_q;
    logic [FRAME_LEN-1:0] sh_q;
    logic [FRAME_LEN-1:0] sh_d;
    assign out_ready = !stall;
    assign sh_d      = {sh_q[FRAME_LEN-2:0], out_data[0]};
    // start bit opens frame; only whole frames handed on
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            n_q      <= 0;
            frames_q <= 0;
            sh_q     <= '0;
            frame_q  <= '0;
        end
        else if (listen && out_valid && out_ready && (n_q > 0 || out_data[0] == START_BIT))
        begin
            sh_q <= sh_d;
            n_q  <= (n_q == FRAME_LEN - 1) ? 0 : n_q + 1;
            if (n_q == FRAME_LEN - 1)
            begin
                frame_q  <= sh_d;
                frames_q <= frames_q + 1;
            end
        end
    end
endmodule : fdpm_sink

// >>> fdpm_top_bench.sv
// Bench for fdpm_top: registers, flags, buffering and monitor frames.
// Assumes fdpm_sink as the far side of the stream.
`timescale 1ns/1ns
module fdpm_top_bench import fdpm_pkg::*;;
    logic                     sys_clk, reset, wr_en, rd_en, strobe, stall, listen, ready, valid, ser, in_rdy;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W-1:0]        wdata, rdata;
    logic [3:0][SAMPLE_W-1:0] smp;
    logic [3:0]               flag;
    logic [1:0]               cbc;
    logic [63:0]              data;
    logic [3:0][MAG_W-1:0]    hold;
    logic [FRAME_LEN-1:0]     frame;
    logic [5:0][7:0]          cfg = {8'h00, 8'h03, 8'h00, 8'h80, 8'h01, 8'h00};
    int                       frames, cyc = 0, n_mismatch = 0, n_compared = 0;
    fdpm_top u_fdpm_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wdata), .reg_rdata(rdata), .adc_sample(smp), .dec_strobe(strobe),
        .in_ready(in_rdy), .monitor_period_value(24'h00001e), .ctrl_bit_count(cbc), .out_valid(valid),
        .out_ready(ready), .out_data(data), .monitor_peak_hold(hold), .embedded_monitor_serial(ser),
        .threshold_flag_pin_a(flag[0]), .threshold_flag_pin_b(flag[1]), .threshold_flag_pin_c(flag[2]),
        .threshold_flag_pin_d(flag[3]));
    fdpm_sink u_fdpm_sink (.sys_clk(sys_clk), .reset(reset), .stall(stall), .listen(listen),
        .out_valid(valid), .out_data(data), .out_ready(ready), .frame_q(frame), .frames_q(frames));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        {addr, wdata, wr_en} = {a, d, 1'b1};
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        {addr, rd_en} = {a, 1'b1};
        tick(1);
        rd_en = 1'b0;
        tick(1);
        check(rdata, e);
    endtask : rd
    function automatic logic [FRAME_LEN-1:0] fr(input logic [MAG_W-1:0] p);
        logic [19:0]          w;
        logic [FRAME_LEN-1:0] f;
        w = {7'h00, p};
        for (int i = 0; i < SUB_CNT; i++) f[24-5*i -: 5] = {START_BIT, w[19-4*i -: 4]};
        return f;
    endfunction : fr
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        {reset, wr_en, rd_en, strobe, stall, listen, addr, wdata, smp, cbc} = {6'h20, 76'h1};
        tick(6);
        reset = 1'b0;
        check(ser, 1);
        for (int i = 0; i < 6; i++) wr(OFS_UPPER_LO + 10'(i), cfg[i]);
        rd(OFS_DWELL_LO, 8'h03);
        rd(10'h250, 8'h00);
        smp = {14'h0000, 14'h0100, 14'h3eff, 14'h0101};
        tick(1);
        smp = '0;
        tick(1);
        check(flag, 4'h3);
        tick(3);
        check(flag, 4'h3);
        tick(2);
        check(flag, 4'h0);
        smp[0] = 14'h0101;
        tick(1);
        smp[0] = 14'h0080;
        tick(1);
        smp[0] = 14'h0000;
        tick(4);
        check(flag[0], 1);
        {stall, strobe} = 2'h3;
        tick(10);
        strobe = 1'b0;
        check({in_rdy, valid}, 2'h1);
        stall = 1'b0;
        tick(12);
        check({flag[0], valid}, 0);
        wr(OFS_LINK_A, 8'h03);
        wr(OFS_LINK_B, 8'h02);
        for (int k = 2; k < 4; k++)
        begin
            {cbc, smp[0], strobe} = {2'(k), 14'h0054, 1'b1};
            tick(1);
            strobe = 1'b0;
            check(data[15:0], 16'h0150 | (16'h1 << (k - 1)));
            tick(1);
        end
        cbc = 2'h1;
        wr(OFS_MON_CTRL, 8'h02);
        rd(OFS_MON_CTRL, 8'h02);
        listen = 1'b1;
        for (int i = 0; i < 100; i++)
        begin
            {smp[0], strobe} = {i[0] ? 14'h3f10 : 14'h00a5, 1'b1};
            if (i == 31)
                check(ser, START_BIT);
            tick(1);
            strobe = 1'b0;
            tick(1);
        end
        tick(4);
        check(hold[0], 13'h0f0);
        check(frames, 2);
        check(frame, fr(13'h0f0));
        results();
    end
endmodule : fdpm_top_bench
